/* File: hw/rcs_consts.svh */
// Register map, field positions, reset values and timing figures of the read cycle controller.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
// Register byte addresses.
`define RCS_ADDR_CTRL   5'h00
`define RCS_ADDR_AUTO   5'h04
`define RCS_ADDR_TIMER  5'h08
`define RCS_ADDR_CMD    5'h0c
`define RCS_ADDR_STATUS 5'h10
`define RCS_ADDR_BEAT   5'h14
// Control register fields.
`define RCS_CTRL_START  1:0
`define RCS_CTRL_STOP   4:2
`define RCS_CTRL_BEEP   5
`define RCS_CTRL_BEAT   6
`define RCS_CTRL_EARLY  7
`define RCS_CTRL_HOST   11:8
`define RCS_CTRL_RST    32'h0000_0120
// Command register bits.
`define RCS_CMD_START   0
`define RCS_CMD_STOP    1
// Start source codes.
`define RCS_SRC_SENSOR  2'h0
`define RCS_SRC_CMD     2'h1
`define RCS_SRC_AUTO    2'h2
`define RCS_SRC_FREE    2'h3
// Stop source codes.
`define RCS_STP_CYCLE   3'h0
`define RCS_STP_EXIT    3'h1
`define RCS_STP_CMD     3'h2
`define RCS_STP_TIMER   3'h3
`define RCS_STP_COND    3'h4
// Reset periods in clock cycles.
`define RCS_AUTO_RST    32'h0000_1000
`define RCS_TIMER_RST   32'h0000_0800
`define RCS_BEAT_RST    32'h0001_0000
// Code count limit per reading interval.
`define RCS_MAX_CODES   4'hf
// Timing: clock period and indicator flash length in ns.
`define RCS_CLK_NS      4
`define RCS_FLASH_NS    100000000
`endif

/* File: hw/rcs_pkg.sv */
// Types shared by the read cycle controller.
package rcs_pkg;
  // Colour drive of the status indicator.
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } rcs_led_type;
  // One read result handed to the output interfaces.
  typedef struct packed {
    logic       valid;
    logic       good;
    logic [3:0] count;
  } rcs_result_type;
  // Device operating state.
  typedef enum logic [2:0] {
    RCS_DOWNLOAD = 3'b000,
    RCS_SELFTEST = 3'b001,
    RCS_READY    = 3'b010,
    RCS_FWLOAD   = 3'b011,
    RCS_FAULT    = 3'b100
  } rcs_state_type;
endpackage

/* File: hw/rcs_ctrl.sv */
// Read cycle controller with status indicator and Avalon-MM register slave.
`include "rcs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module rcs_ctrl #(
  parameter int FLASH_CYC = `RCS_FLASH_NS / `RCS_CLK_NS
) (
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  input  wire logic [4:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  output logic [31:0]              avs_readdata_out,
  output logic                     avs_waitrequest_out,
  input  wire logic                sensor_entry_in,
  input  wire logic                sensor_exit_in,
  input  wire logic                param_done_in,
  input  wire logic                selftest_pass_in,
  input  wire logic                hardware_fault_in,
  input  wire logic                fw_busy_in,
  input  wire logic                fw_done_in,
  input  wire logic                fw_fail_in,
  input  wire logic                code_in,
  input  wire logic                cond_met_in,
  output rcs_pkg::rcs_led_type     led_out,
  output logic                     beeper_out,
  output logic                     heartbeat_out,
  output logic                     interval_out,
  output rcs_pkg::rcs_result_type  host_result_out,
  output logic [3:0]               host_sel_out,
  output rcs_pkg::rcs_result_type  aux_result_out
);
  // ****************************************
  // Register slave
  // ****************************************
  logic [31:0] ctrl_reg;   // Source selects and option enables.
  logic [31:0] auto_reg;   // Auto-pulse period in cycles.
  logic [31:0] timer_reg;  // Stop timer length in cycles.
  logic [31:0] beat_reg;   // Heartbeat period in cycles.
  logic        ack_reg;    // Ends the single wait cycle of each access.
  logic [31:0] rdata_next; // Read multiplexer.
  wire  wr_take  = avs_write_in & ack_reg;
  wire  wr_ctrl  = wr_take & (avs_address_in == `RCS_ADDR_CTRL);
  wire  wr_auto  = wr_take & (avs_address_in == `RCS_ADDR_AUTO);
  wire  wr_timer = wr_take & (avs_address_in == `RCS_ADDR_TIMER);
  wire  wr_beat  = wr_take & (avs_address_in == `RCS_ADDR_BEAT);
  wire  wr_cmd   = wr_take & (avs_address_in == `RCS_ADDR_CMD);
  wire  cmd_start = wr_cmd & avs_writedata_in[`RCS_CMD_START];
  wire  cmd_stop  = wr_cmd & avs_writedata_in[`RCS_CMD_STOP];
  // Every access waits exactly one cycle, so read data can be registered.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
  // Acknowledge pulses high for one cycle per access.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
    end
  end
  // Writable registers keep their value until software writes them.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg  <= `RCS_CTRL_RST;
      auto_reg  <= `RCS_AUTO_RST;
      timer_reg <= `RCS_TIMER_RST;
      beat_reg  <= `RCS_BEAT_RST;
    end else begin
      if (wr_ctrl)  ctrl_reg  <= avs_writedata_in;
      if (wr_auto)  auto_reg  <= avs_writedata_in;
      if (wr_timer) timer_reg <= avs_writedata_in;
      if (wr_beat)  beat_reg  <= avs_writedata_in;
    end
  end
  // ****************************************
  // Sensor synchronisers
  // ****************************************
  wire  [1:0] sens_pin = {sensor_exit_in, sensor_entry_in};
  logic [1:0] sens_lvl_reg; // Filtered sensor levels.
  logic [1:0] sens_old_reg; // Levels one cycle earlier.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      logic [2:0] q_reg; // Three-stage capture chain.
      // A level change counts once stages two and three agree.
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          q_reg           <= 3'h0;
          sens_lvl_reg[g] <= 1'b0;
          sens_old_reg[g] <= 1'b0;
        end else begin
          q_reg <= {q_reg[1:0], sens_pin[g]};
          if (q_reg[1] == q_reg[2]) sens_lvl_reg[g] <= q_reg[2];
          sens_old_reg[g] <= sens_lvl_reg[g];
        end
      end
    end
  endgenerate
  wire entry_rise = sens_lvl_reg[0] & ~sens_old_reg[0];
  wire entry_fall = ~sens_lvl_reg[0] & sens_old_reg[0];
  wire exit_rise  = sens_lvl_reg[1] & ~sens_old_reg[1];
  // ****************************************
  // Device state
  // ****************************************
  rcs_pkg::rcs_state_type state_reg;
  rcs_pkg::rcs_state_type state_next;
  // Power-up walks download, self-test, then ready; firmware loads loop back.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rcs_pkg::RCS_DOWNLOAD: if (param_done_in) state_next = rcs_pkg::RCS_SELFTEST;
      rcs_pkg::RCS_SELFTEST: begin
        if (hardware_fault_in) state_next = rcs_pkg::RCS_FAULT;
        else if (selftest_pass_in) state_next = rcs_pkg::RCS_READY;
      end
      rcs_pkg::RCS_READY: begin
        if (hardware_fault_in) state_next = rcs_pkg::RCS_FAULT;
        else if (fw_busy_in) state_next = rcs_pkg::RCS_FWLOAD;
      end
      rcs_pkg::RCS_FWLOAD: begin
        if (fw_fail_in) state_next = rcs_pkg::RCS_FAULT;
        else if (fw_done_in) state_next = rcs_pkg::RCS_SELFTEST;
      end
      rcs_pkg::RCS_FAULT: if (fw_busy_in) state_next = rcs_pkg::RCS_FWLOAD;
      default: state_next = rcs_pkg::RCS_DOWNLOAD;
    endcase
  end
  // State register.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) state_reg <= rcs_pkg::RCS_DOWNLOAD;
    else state_reg <= state_next;
  end
  wire ready = (state_reg == rcs_pkg::RCS_READY);
  // ****************************************
  // Read cycle control
  // ****************************************
  logic        open_reg;   // Reading interval is open.
  logic [31:0] auto_cnt_reg;
  logic [31:0] tmr_cnt_reg;
  logic [3:0]  codes_reg;  // Codes seen in the current interval.
  logic        early_reg;  // Result already sent during this interval.
  wire [1:0] start_src = ctrl_reg[`RCS_CTRL_START];
  wire [2:0] stop_src  = ctrl_reg[`RCS_CTRL_STOP];
  wire auto_hit = (auto_cnt_reg >= auto_reg);
  wire start_sel = (start_src == `RCS_SRC_SENSOR) ? entry_rise :
                   (start_src == `RCS_SRC_CMD)    ? cmd_start  :
                   (start_src == `RCS_SRC_AUTO)   ? auto_hit   : 1'b1;
  // Starts are only taken while ready and no interval is open.
  wire start_ev = ready & ~open_reg & start_sel;
  wire stop_sel = (stop_src == `RCS_STP_CYCLE) ? entry_fall :
                  (stop_src == `RCS_STP_EXIT)  ? exit_rise  :
                  (stop_src == `RCS_STP_CMD)   ? cmd_stop   :
                  (stop_src == `RCS_STP_TIMER) ? (tmr_cnt_reg >= timer_reg) :
                  (stop_src == `RCS_STP_COND)  ? cond_met_in : 1'b0;
  // A fault or firmware load also closes an open interval.
  wire stop_ev  = open_reg & (stop_sel | ~ready);
  wire early_ev = open_reg & ~stop_ev & ~early_reg & ctrl_reg[`RCS_CTRL_EARLY] & cond_met_in;
  wire good_now = (codes_reg != 4'h0);
  // Interval, counters and code tally.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      open_reg     <= 1'b0;
      auto_cnt_reg <= 32'h0;
      tmr_cnt_reg  <= 32'h0;
      codes_reg    <= 4'h0;
      early_reg    <= 1'b0;
    end else begin
      // The auto-pulse counter runs freely while ready, is held at zero otherwise, and restarts on each pulse.
      auto_cnt_reg <= (auto_hit | ~ready) ? 32'h0 : auto_cnt_reg + 32'h1;
      if (start_ev) begin
        open_reg    <= 1'b1;
        tmr_cnt_reg <= 32'h0;
        codes_reg   <= 4'h0;
        early_reg   <= 1'b0;
      end else if (stop_ev) begin
        open_reg <= 1'b0;
      end else if (open_reg) begin
        tmr_cnt_reg <= tmr_cnt_reg + 32'h1;
        // Code count saturates at the interval limit.
        if (code_in && codes_reg != `RCS_MAX_CODES) codes_reg <= codes_reg + 4'h1;
        if (early_ev) early_reg <= 1'b1;
      end
    end
  end
  // ****************************************
  // Result output
  // ****************************************
  rcs_pkg::rcs_result_type res_next;
  // One result per interval: early when conditions hold, else at the end.
  assign res_next = {early_ev | (stop_ev & ~early_reg), good_now, codes_reg};
  // Result registers feed both output interfaces.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      host_result_out <= '0;
      aux_result_out  <= '0;
      host_sel_out    <= 4'h0;
    end else begin
      aux_result_out  <= res_next;
      host_result_out <= res_next;
      host_sel_out    <= ctrl_reg[`RCS_CTRL_HOST];
    end
  end
  // ****************************************
  // Indicator, beeper and heartbeat
  // ****************************************
  logic [31:0] flash_cnt_reg; // Remaining flash or blink cycles.
  logic        flash_good_reg;
  logic        blink_reg;     // Alternation phase during firmware load.
  logic [31:0] beat_cnt_reg;
  rcs_pkg::rcs_led_type led_next;
  wire flashing = (flash_cnt_reg != 32'h0);
  // Leaving firmware load drops any blink phase still counting down.
  wire fw_leave = (state_reg == rcs_pkg::RCS_FWLOAD) & (state_next != rcs_pkg::RCS_FWLOAD);
  wire beat_hit = ready & ctrl_reg[`RCS_CTRL_BEAT] & (beat_cnt_reg >= beat_reg);
  // Colour selection per state.
  always_comb begin
    led_next = '0;
    unique case (state_reg)
      rcs_pkg::RCS_FAULT:  led_next.red = 1'b1;
      rcs_pkg::RCS_FWLOAD: begin
        led_next.red  = blink_reg;
        led_next.blue = ~blink_reg;
      end
      rcs_pkg::RCS_READY: begin
        if (flashing && flash_good_reg) led_next.green = 1'b1;
        else if (flashing) led_next.red = 1'b1;
        else led_next.blue = 1'b1;
      end
      default: led_next = '0;
    endcase
  end
  // Flash timer, blink phase, heartbeat counter and output flops.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flash_cnt_reg  <= 32'h0;
      flash_good_reg <= 1'b0;
      blink_reg      <= 1'b0;
      beat_cnt_reg   <= 32'h0;
      led_out        <= '0;
      beeper_out     <= 1'b0;
      heartbeat_out  <= 1'b0;
      interval_out   <= 1'b0;
    end else begin
      if (stop_ev) begin
        flash_cnt_reg  <= 32'(FLASH_CYC);
        flash_good_reg <= good_now;
      end else if (fw_leave) begin
        flash_cnt_reg <= 32'h0;
      end else if (flashing) begin
        flash_cnt_reg <= flash_cnt_reg - 32'h1;
      end else if (state_reg == rcs_pkg::RCS_FWLOAD) begin
        flash_cnt_reg <= 32'(FLASH_CYC);
        blink_reg     <= ~blink_reg;
      end
      beat_cnt_reg  <= beat_hit ? 32'h0 : beat_cnt_reg + 32'h1;
      heartbeat_out <= beat_hit;
      led_out       <= led_next;
      beeper_out    <= ready & flashing & flash_good_reg & ctrl_reg[`RCS_CTRL_BEEP];
      interval_out  <= open_reg;
    end
  end
  // ****************************************
  // Register read
  // ****************************************
  always_comb begin
    rdata_next = 32'h0;
    unique case (avs_address_in)
      `RCS_ADDR_CTRL:   rdata_next = ctrl_reg;
      `RCS_ADDR_AUTO:   rdata_next = auto_reg;
      `RCS_ADDR_TIMER:  rdata_next = timer_reg;
      `RCS_ADDR_BEAT:   rdata_next = beat_reg;
      `RCS_ADDR_STATUS: rdata_next = {20'h0, led_out, flash_good_reg, codes_reg,
                                      open_reg, state_reg};
      default:          rdata_next = 32'h0;
    endcase
  end
  // Read data is captured on the wait cycle and stands at the taking edge.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) avs_readdata_out <= 32'h0;
    else if (avs_read_in && !ack_reg) avs_readdata_out <= rdata_next;
  end
  // ****************************************
  // Assertions
  // ****************************************
  start_opens_a: assert property (@(posedge clock_in) disable iff (rst_in)
    start_ev |=> open_reg && codes_reg == 4'h0 && tmr_cnt_reg == 32'h0)
    else $error("start did not open interval");
  cmd_start_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (cmd_start && ready && !open_reg && start_src == `RCS_SRC_CMD) |=> open_reg)
    else $error("command start ignored");
  no_restart_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (open_reg && !stop_ev) |=> open_reg && tmr_cnt_reg == $past(tmr_cnt_reg) + 32'h1)
    else $error("open interval restarted");
  stop_closes_a: assert property (@(posedge clock_in) disable iff (rst_in)
    stop_ev |=> !open_reg ##1 interval_out == 1'b0)
    else $error("stop did not close interval");
  code_limit_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (open_reg && codes_reg == `RCS_MAX_CODES && !start_ev) |=> codes_reg == `RCS_MAX_CODES)
    else $error("code count passed limit");
  result_end_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (stop_ev && !early_reg) |=> host_result_out.valid && aux_result_out.valid)
    else $error("no result at interval end");
  good_flash_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (stop_ev && good_now && ready && state_next == rcs_pkg::RCS_READY)
    |=> ##1 led_out.green && !led_out.blue)
    else $error("good read did not flash green");
  fault_red_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_reg == rcs_pkg::RCS_FAULT) |=> led_out == 3'b100)
    else $error("fault not steady red");
  ready_blue_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (ready && !flashing) |=> led_out.blue && !led_out.red)
    else $error("ready not blue");
  beep_off_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !ctrl_reg[`RCS_CTRL_BEEP] |=> !beeper_out)
    else $error("beeper sounded while disabled");
endmodule // rcs_ctrl
`default_nettype wire

/* File: testbench/rcs_sensor_model.sv */
// Model of the read-cycle sensors and the code decoder that feed the controller.
`timescale 1ns/10ps
`default_nettype none
module rcs_sensor_model (
  input  wire logic clock_in,
  output logic      sensor_entry_out,
  output logic      sensor_exit_out,
  output logic      code_out
);
  // ****************************************
  // Idle levels
  // ****************************************
  // All lines rest low from time zero, so the synchronisers never see an unknown.
  initial begin
    sensor_entry_out = 1'b0;
    sensor_exit_out  = 1'b0;
    code_out         = 1'b0;
  end
  // Lets a number of clock edges pass.
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Sends one-cycle code pulses, one every other cycle.
  task automatic codes(input int n);
    repeat (n) begin
      @(posedge clock_in);
      code_out <= 1'b1;
      @(posedge clock_in);
      code_out <= 1'b0;
    end
  endtask
  // One object crosses the entry sensor; only one object is ever in the field.
  task automatic pass_entry(input int n);
    @(posedge clock_in);
    sensor_entry_out <= 1'b1;
    idle(8);
    codes(n);
    idle(2);
    sensor_entry_out <= 1'b0;
  endtask
  // The same object later reaches the exit sensor.
  task automatic pass_exit;
    @(posedge clock_in);
    sensor_exit_out <= 1'b1;
    idle(6);
    sensor_exit_out <= 1'b0;
  endtask
endmodule // rcs_sensor_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking testbench of the read cycle controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock_in = 1'b0, rst_in;
  logic [4:0] avs_address_in;
  logic avs_read_in, avs_write_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q_r;
  logic avs_waitrequest_out, param_done_in, selftest_pass_in;
  logic hardware_fault_in, fw_busy_in, fw_done_in;
  logic fw_fail_in, cond_met_in, sensor_entry, sensor_exit, code;
  logic beeper_out, heartbeat_out, interval_out, ival_q = 1'b0;
  logic [3:0] host_sel_out;
  rcs_pkg::rcs_led_type led_out;
  rcs_pkg::rcs_result_type host_result_out, aux_result_out, last_res, last_aux;
  int n_fail = 0, num_checks = 0, n_res = 0, n_open = 0, n_beat = 0, cyc = 0, r, o;
  // ****************************************
  // Clock, design and partner
  // ****************************************
  // A 250 MHz clock.
  always #2 clock_in = ~clock_in;
  rcs_ctrl #(.FLASH_CYC(8)) rcs_ctrl_inst (.clock_in(clock_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .sensor_entry_in(sensor_entry), .sensor_exit_in(sensor_exit),
    .param_done_in(param_done_in), .selftest_pass_in(selftest_pass_in),
    .hardware_fault_in(hardware_fault_in), .fw_busy_in(fw_busy_in),
    .fw_done_in(fw_done_in), .fw_fail_in(fw_fail_in), .code_in(code),
    .cond_met_in(cond_met_in), .led_out(led_out), .beeper_out(beeper_out),
    .heartbeat_out(heartbeat_out), .interval_out(interval_out),
    .host_result_out(host_result_out), .host_sel_out(host_sel_out),
    .aux_result_out(aux_result_out));
  rcs_sensor_model rcs_sensor_model_inst (.clock_in(clock_in),
    .sensor_entry_out(sensor_entry), .sensor_exit_out(sensor_exit), .code_out(code));
  // ****************************************
  // Monitors and tasks
  // ****************************************
  // Catches result pulses, interval openings, heartbeats, and cuts a hang short.
  always @(posedge clock_in) begin
    if (host_result_out.valid === 1'b1) begin
      n_res <= n_res + 1;
      last_res <= host_result_out;
      last_aux <= aux_result_out;
    end
    if (interval_out === 1'b1 && ival_q !== 1'b1) n_open <= n_open + 1;
    ival_q <= interval_out;
    if (heartbeat_out === 1'b1) n_beat <= n_beat + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    // Only the bench timeout ends a wait that never sees an answer.
    do begin
      @(posedge clock_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0);
    q_r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    // The slave inserts exactly one wait cycle per access.
    chk("bus cycles", 32'h2, k);
  endtask
  // Waits, bounded, for a result pulse beyond the count given.
  task automatic wait_res(input int old);
    int k;
    for (k = 0; k < 300 && n_res == old; k++) @(posedge clock_in);
    chk("result seen", 32'h1, {31'h0, n_res != old});
  endtask
  // Prints the counts, then the verdict, and ends the run.
  task automatic final_report;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    // Reset asserted and every request line idle before the first edge.
    rst_in <= 1'b1;
    avs_address_in <= 5'h00;
    avs_writedata_in <= 32'h0;
    {avs_read_in, avs_write_in} <= 2'h0;
    {param_done_in, selftest_pass_in, hardware_fault_in} <= 3'h0;
    {fw_busy_in, fw_done_in, fw_fail_in, cond_met_in} <= 4'h0;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h0, {29'h0, q_r[2:0]});
    chk("led", 32'h0, {29'h0, led_out});
    bus(0, 5'h00, 0); chk("ctrl", 32'h120, q_r);
    bus(0, 5'h04, 0); chk("auto", 32'h1000, q_r);
    bus(0, 5'h08, 0); chk("timer", 32'h800, q_r);
    bus(0, 5'h14, 0); chk("beat", 32'h10000, q_r);
    bus(0, 5'h18, 0); chk("unmapped", 32'h0, q_r);
    @(posedge clock_in) param_done_in <= 1'b1;
    @(posedge clock_in) param_done_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h1, {29'h0, q_r[2:0]});
    @(posedge clock_in) selftest_pass_in <= 1'b1;
    @(posedge clock_in) selftest_pass_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h2, {29'h0, q_r[2:0]});
    chk("led", 32'h1, {29'h0, led_out});
    // Sensor start and stop on a single entry sensor, three codes.
    r = n_res;
    fork
      rcs_sensor_model_inst.pass_entry(3);
      begin rcs_sensor_model_inst.idle(11); chk("open", 32'h1, {31'h0, interval_out}); end
    join
    wait_res(r); chk("result", 32'h33, {26'h0, last_res});
    chk("aux", 32'h33, {26'h0, last_aux});
    rcs_sensor_model_inst.idle(2); chk("led", 32'h2, {29'h0, led_out});
    chk("beeper", 32'h1, {31'h0, beeper_out});
    rcs_sensor_model_inst.idle(14); chk("led", 32'h1, {29'h0, led_out});
    // Command start and stop, beeper off, sixteen codes and a start while open.
    bus(1, 5'h00, 32'ha09); rcs_sensor_model_inst.idle(2);
    chk("host sel", 32'ha, {28'h0, host_sel_out});
    r = n_res; o = n_open;
    bus(1, 5'h0c, 32'h1);
    rcs_sensor_model_inst.codes(16);
    bus(1, 5'h0c, 32'h1);
    bus(1, 5'h0c, 32'h2); wait_res(r); chk("result", 32'h3f, {26'h0, last_res});
    chk("opens", 32'h1, n_open - o);
    r = n_res;
    bus(1, 5'h0c, 32'h1);
    bus(1, 5'h0c, 32'h2); wait_res(r); chk("result", 32'h20, {26'h0, last_res});
    rcs_sensor_model_inst.idle(2); chk("led", 32'h4, {29'h0, led_out});
    chk("beeper", 32'h0, {31'h0, beeper_out});
    // Entry sensor starts, exit sensor stops.
    bus(1, 5'h00, 32'h124); r = n_res;
    rcs_sensor_model_inst.pass_entry(2);
    rcs_sensor_model_inst.idle(6); chk("open", 32'h1, {31'h0, interval_out});
    rcs_sensor_model_inst.pass_exit; wait_res(r); chk("result", 32'h32, {26'h0, last_res});
    // Timer stop.
    bus(1, 5'h08, 32'd20); bus(1, 5'h00, 32'h00d);
    bus(1, 5'h0c, 32'h1);
    rcs_sensor_model_inst.idle(8); chk("open", 32'h1, {31'h0, interval_out});
    rcs_sensor_model_inst.idle(30); chk("open", 32'h0, {31'h0, interval_out});
    // Condition stop.
    bus(1, 5'h00, 32'h011); r = n_res;
    bus(1, 5'h0c, 32'h1);
    rcs_sensor_model_inst.codes(1);
    cond_met_in <= 1'b1; wait_res(r); chk("result", 32'h31, {26'h0, last_res});
    cond_met_in <= 1'b0;
    // Early output while open, then no result at the end.
    bus(1, 5'h00, 32'h089); r = n_res;
    bus(1, 5'h0c, 32'h1);
    rcs_sensor_model_inst.codes(2);
    cond_met_in <= 1'b1; wait_res(r); chk("result", 32'h32, {26'h0, last_res});
    chk("open", 32'h1, {31'h0, interval_out});
    cond_met_in <= 1'b0; r = n_res;
    bus(1, 5'h0c, 32'h2);
    rcs_sensor_model_inst.idle(20); chk("results", 32'h0, n_res - r);
    // Auto pulse intervals.
    bus(1, 5'h04, 32'd40); bus(1, 5'h08, 32'd5); o = n_open;
    bus(1, 5'h00, 32'h00e);
    rcs_sensor_model_inst.idle(200);
    chk("auto opens", 32'h1, {31'h0, (n_open - o) >= 3 && (n_open - o) <= 7});
    bus(1, 5'h00, 32'h009); bus(1, 5'h0c, 32'h2);
    // Heartbeat pulses.
    bus(1, 5'h14, 32'd10); bus(1, 5'h00, 32'h049); o = n_beat;
    rcs_sensor_model_inst.idle(110);
    chk("beats", 32'h1, {31'h0, (n_beat - o) >= 9 && (n_beat - o) <= 11});
    bus(1, 5'h00, 32'h009);
    // Free start reopens at once after each stop.
    o = n_open;
    bus(1, 5'h00, 32'h00b); bus(1, 5'h0c, 32'h2);
    rcs_sensor_model_inst.idle(4); chk("free opens", 32'h2, n_open - o);
    chk("open", 32'h1, {31'h0, interval_out});
    bus(1, 5'h00, 32'h009); bus(1, 5'h0c, 32'h2);
    // Failed firmware load leaves steady red.
    @(posedge clock_in) fw_busy_in <= 1'b1;
    bus(0, 5'h10, 0); chk("state", 32'h3, {29'h0, q_r[2:0]});
    @(posedge clock_in) fw_fail_in <= 1'b1;
    @(posedge clock_in) fw_fail_in <= 1'b0;
    fw_busy_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h4, {29'h0, q_r[2:0]});
    chk("led", 32'h4, {29'h0, led_out});
    rcs_sensor_model_inst.idle(20); chk("led", 32'h4, {29'h0, led_out});
    // A reload that completes goes back through self-test to steady blue.
    @(posedge clock_in) fw_busy_in <= 1'b1;
    @(posedge clock_in) fw_busy_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h3, {29'h0, q_r[2:0]});
    @(posedge clock_in) fw_done_in <= 1'b1;
    @(posedge clock_in) fw_done_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h1, {29'h0, q_r[2:0]});
    chk("led", 32'h0, {29'h0, led_out});
    @(posedge clock_in) selftest_pass_in <= 1'b1;
    @(posedge clock_in) selftest_pass_in <= 1'b0;
    rcs_sensor_model_inst.idle(2); chk("led", 32'h1, {29'h0, led_out});
    // A hardware fault while ready shows steady red.
    @(posedge clock_in) hardware_fault_in <= 1'b1;
    @(posedge clock_in) hardware_fault_in <= 1'b0;
    bus(0, 5'h10, 0); chk("state", 32'h4, {29'h0, q_r[2:0]});
    rcs_sensor_model_inst.idle(2); chk("led", 32'h4, {29'h0, led_out});
    final_report;
  end
endmodule // tb
`default_nettype wire
